// ### pkg/sarcv_pkg.sv
// Constants, types and timing counts for the SAR conversion and readout block
// Functional notes
// - Sample serial-input level at each conversion start
// - High selects chip-select mode, low selects chain
// - 3-wire: conversion-start pin also selects readout
// - 4-wire: serial-input pin selects readout
// - 4-wire: drive MSB once serial-input falls
// - 4-wire: release output on deselect or last bit
// - Shift result out on serial-clock falling edges
// - Conversion lasts 500 to 8800 ns internally
// - Chain mode: capture upstream data on falling edges
// - Result word presented in two's complement
package sarcv_pkg;

    localparam int RESULT_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h10;

    localparam int CLK_NS = 40;
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 8800;
    localparam int CONV_NS = 4000;
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONVCNT_W = 8;
    localparam logic [CONVCNT_W-1:0] CONV_LAST = 8'(CONV_CYC - 1);

    // Host-side spacing, kept for the bench
    localparam int ACQ_MIN_NS = 1200;
    localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int START_SPACE_NS = 10000;
    localparam int START_SPACE_CYC = (START_SPACE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNV_LOW_NS = 20;
    localparam int CNV_LOW_CYC = (CNV_LOW_NS + CLK_NS - 1) / CLK_NS;

    // Output timing bounds; sampling latency exceeds them at this clock
    localparam real DRIVE_MAX_NS = 12.3;
    localparam real RELEASE_MAX_NS = 13.2;
    localparam int DRIVE_MAX_CYC = (DRIVE_MAX_NS < CLK_NS) ? 1 :
        $rtoi(DRIVE_MAX_NS / CLK_NS);
    localparam int RELEASE_MAX_CYC = (RELEASE_MAX_NS < CLK_NS) ? 1 :
        $rtoi(RELEASE_MAX_NS / CLK_NS);

    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {
        SARCV_IDLE = 2'b00,
        SARCV_CONVERT = 2'b01,
        SARCV_ACQUIRE = 2'b10
    } sarcv_phase_t;

    typedef enum logic [1:0] {
        SARCV_SEL_NONE = 2'b00,
        SARCV_SEL_THREE = 2'b01,
        SARCV_SEL_FOUR = 2'b10
    } sarcv_sel_t;

    typedef struct packed {
        logic conversion_start_pin;
        logic serialIn;
        logic serialClk;
    } sarcv_pins_t;

    typedef struct packed {
        logic serialOut;
        logic serialOutEn_n;
    } sarcv_out_t;

endpackage : sarcv_pkg

// ### src/sarcv_top.sv
// Sample FIFO and conversion sequencer with serial readout
`timescale 1ns/100ps
`default_nettype none

module sarcv_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } sarcv_fifo_state_t;

    sarcv_fifo_state_t s;
    sarcv_fifo_state_t next_s;
    logic doWrite;
    logic doRead;

    assign inReady = (s.count != FULL_COUNT);
    assign outValid = (s.count != '0);
    assign outData = s.mem[s.rdPtr];

    always_comb begin
        next_s = s;
        doWrite = inValid && inReady;
        doRead = outValid && outReady;
        if (doWrite) begin
            next_s.mem[s.wrPtr] = inData;
            next_s.wrPtr = (s.wrPtr == LAST_PTR) ? '0 : s.wrPtr + 1'b1;
        end
        if (doRead) begin
            next_s.rdPtr = (s.rdPtr == LAST_PTR) ? '0 : s.rdPtr + 1'b1;
        end
        case ({doWrite, doRead})
            2'b10: next_s.count = s.count + 1'b1;
            2'b01: next_s.count = s.count - 1'b1;
            default: next_s.count = s.count;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : sarcv_fifo

module sarcv_top
    import sarcv_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire sarcv_pins_t pins,
    output sarcv_out_t pinOut,
    input wire logic [RESULT_W-1:0] sampleData,
    input wire logic sampleValid,
    output logic sampleReady,
    output logic busy,
    output logic chainMode
);
    typedef struct packed {
        logic [2:0] syncCnv;
        logic [2:0] syncDin;
        logic [2:0] syncClk;
        logic cnvLvl;
        logic dinLvl;
        logic clkLvl;
        sarcv_phase_t phase;
        logic chain;
        sarcv_sel_t sel;
        logic [CONVCNT_W-1:0] convCnt;
        logic [RESULT_W-1:0] sample;
        logic [RESULT_W-1:0] shiftReg;
        logic [BITCNT_W-1:0] bitCnt;
        logic drive;
    } sarcv_state_t;

    sarcv_state_t s;
    sarcv_state_t next_s;
    logic [RESULT_W-1:0] fifoData;
    logic fifoValid;
    logic fifoPop;
    logic cnvRise;
    logic cnvFall;
    logic dinFall;
    logic clkFall;
    logic selActive;

    // Conversion only consumes a word per start, so the FIFO can fill
    sarcv_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .inData(sampleData),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    always_comb begin
        next_s = s;
        cnvRise = 1'b0;
        cnvFall = 1'b0;
        dinFall = 1'b0;
        clkFall = 1'b0;
        selActive = 1'b0;
        fifoPop = 1'b0;

        // Three-stage sampling; a level counts once stages two and three agree
        next_s.syncCnv = {s.syncCnv[1:0], pins.conversion_start_pin};
        next_s.syncDin = {s.syncDin[1:0], pins.serialIn};
        next_s.syncClk = {s.syncClk[1:0], pins.serialClk};
        if (s.syncCnv[1] == s.syncCnv[2]) begin
            next_s.cnvLvl = s.syncCnv[2];
        end
        if (s.syncDin[1] == s.syncDin[2]) begin
            next_s.dinLvl = s.syncDin[2];
        end
        if (s.syncClk[1] == s.syncClk[2]) begin
            next_s.clkLvl = s.syncClk[2];
        end
        cnvRise = next_s.cnvLvl && !s.cnvLvl;
        cnvFall = !next_s.cnvLvl && s.cnvLvl;
        dinFall = !next_s.dinLvl && s.dinLvl;
        clkFall = !next_s.clkLvl && s.clkLvl;

        case (s.phase)
            SARCV_IDLE, SARCV_ACQUIRE: begin
                if (cnvRise) begin
                    next_s.chain = !next_s.dinLvl;
                    next_s.phase = SARCV_CONVERT;
                    next_s.convCnt = '0;
                    next_s.drive = 1'b0;
                    next_s.sel = SARCV_SEL_NONE;
                    fifoPop = fifoValid;
                    // Empty FIFO converts as zero rather than stalling the pin
                    next_s.sample = fifoValid ? fifoData : '0;
                end else if (s.phase == SARCV_ACQUIRE) begin
                    if (s.chain) begin
                        next_s.drive = 1'b1;
                        if (clkFall) begin
                            next_s.shiftReg = {s.shiftReg[RESULT_W-2:0],
                                next_s.dinLvl};
                        end
                    end else begin
                        if (s.sel == SARCV_SEL_NONE) begin
                            if (dinFall) begin
                                next_s.sel = SARCV_SEL_FOUR;
                            end else if (cnvFall && next_s.dinLvl) begin
                                next_s.sel = SARCV_SEL_THREE;
                            end
                        end
                        case (next_s.sel)
                            SARCV_SEL_FOUR: selActive = !next_s.dinLvl;
                            SARCV_SEL_THREE: selActive = !next_s.cnvLvl;
                            default: selActive = 1'b0;
                        endcase
                        if (selActive && s.bitCnt != LAST_BIT) begin
                            next_s.drive = 1'b1;
                            if (clkFall) begin
                                next_s.shiftReg = {s.shiftReg[RESULT_W-2:0],
                                    1'b0};
                                next_s.bitCnt = s.bitCnt + 1'b1;
                                if (next_s.bitCnt == LAST_BIT) begin
                                    next_s.drive = 1'b0;
                                end
                            end
                        end else begin
                            next_s.drive = 1'b0;
                        end
                    end
                end
            end
            SARCV_CONVERT: begin
                // Starts during conversion are ignored
                if (s.convCnt == CONV_LAST) begin
                    next_s.phase = SARCV_ACQUIRE;
                    next_s.shiftReg = s.sample;
                    next_s.bitCnt = '0;
                end else begin
                    next_s.convCnt = s.convCnt + 1'b1;
                end
            end
            default: begin
                next_s.phase = SARCV_IDLE;
                next_s.drive = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s.syncCnv <= SYNC_RESET;
            s.syncDin <= SYNC_RESET;
            s.syncClk <= SYNC_RESET;
            s.cnvLvl <= 1'b0;
            s.dinLvl <= 1'b0;
            s.clkLvl <= 1'b0;
            s.phase <= SARCV_IDLE;
            s.chain <= 1'b0;
            s.sel <= SARCV_SEL_NONE;
            s.convCnt <= '0;
            s.sample <= '0;
            s.shiftReg <= '0;
            s.bitCnt <= '0;
            s.drive <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign pinOut.serialOut = s.shiftReg[RESULT_W-1];
    assign pinOut.serialOutEn_n = !s.drive;
    assign busy = (s.phase == SARCV_CONVERT);
    assign chainMode = s.chain;

endmodule : sarcv_top

`default_nettype wire

// ### verification/sarcv_top_asserts.sv
// Checker for the conversion sequencer pins
`timescale 1ns/100ps
`default_nettype none
module sarcv_top_asserts
    import sarcv_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire sarcv_pins_t pins,
    input wire sarcv_out_t pinOut,
    input wire logic sampleReady,
    input wire logic busy,
    input wire logic chainMode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Saturates so a quiet link clock never wraps back into range
    logic [3:0] sinceFall = 4'hf;
    logic [7:0] busyCnt;
    logic sclkD;
    always_ff @(posedge clk) begin
        sclkD <= pins.serialClk;
        busyCnt <= busy ? busyCnt + 8'h01 : 8'h00;
        sinceFall <= (sclkD && !pins.serialClk) ? 4'h0
            : sinceFall + 4'(sinceFall != 4'hf);
    end
    sequence s_idle;
        !chainMode && pins.serialIn && pins.conversion_start_pin;
    endsequence
    property p_len; $fell(busy) |-> busyCnt == 8'(CONV_CYC);
    endproperty
    a_len: assert property (p_len) else $error("conversion length");
    property p_hiz; busy && $past(busy) |-> pinOut.serialOutEn_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("driven in conversion");
    property p_mode; $changed(chainMode) |-> busy;
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed late");
    property p_start; $rose(busy) |-> $past(pins.conversion_start_pin);
    endproperty
    a_start: assert property (p_start) else $error("start on low pin");
    property p_rel; s_idle [*7] |-> pinOut.serialOutEn_n;
    endproperty
    a_rel: assert property (p_rel) else $error("not released");
    property p_chain; (chainMode && !busy) [*6] |-> !pinOut.serialOutEn_n;
    endproperty
    a_chain: assert property (p_chain) else $error("chain not driven");
    property p_shift; $changed(pinOut.serialOut) && !pinOut.serialOutEn_n
        && !$past(pinOut.serialOutEn_n) |-> sinceFall <= 4'h6;
    endproperty
    a_shift: assert property (p_shift) else $error("shift off clock");
    property p_pop; $rose(sampleReady) |-> busy;
    endproperty
    a_pop: assert property (p_pop) else $error("pop outside start");
endmodule : sarcv_top_asserts
bind sarcv_top sarcv_top_asserts chk (.clk(clk), .resetn(resetn),
    .pins(pins), .pinOut(pinOut), .sampleReady(sampleReady),
    .busy(busy), .chainMode(chainMode));
`default_nettype wire

// ### verification/sarcv_host.sv
// Host model driving the pin link and reading the serial output
`timescale 1ns/100ps
`default_nettype none
module sarcv_host
    import sarcv_pkg::*;
(
    input wire logic clk,
    input wire sarcv_out_t pinOut,
    output var sarcv_pins_t pins
);
    int cyc = 0;
    int last = -START_SPACE_CYC;
    initial pins = '{1'b0, 1'b1, 1'b1};
    always @(negedge clk) cyc <= cyc + 1;
    // Start spacing also covers the acquisition time
    task automatic start(input logic cs);
        while (cyc - last < START_SPACE_CYC) @(negedge clk);
        pins.conversion_start_pin = 1'b0;
        pins.serialIn = cs;
        repeat (4) @(negedge clk);
        pins.conversion_start_pin = 1'b1;
        last = cyc;
        @(negedge clk);
    endtask : start
    // Link clock idles high, runs only inside a frame
    task automatic read(input int n, m, input logic [31:0] din,
        output logic [31:0] got);
        got = '0;
        if (m == 0) pins.serialIn = 1'b0;
        if (m == 1) pins.conversion_start_pin = 1'b0;
        if (m == 2) pins.serialIn = din[31];
        repeat (8) @(negedge clk);
        for (int k = 0; k < n; k++) begin
            // A released output reads back inverted, so a missed drive shows
            got = {got[30:0], pinOut.serialOutEn_n ? !pinOut.serialOut
                : pinOut.serialOut};
            pins.serialClk = 1'b0;
            repeat (4) @(negedge clk);
            pins.serialClk = 1'b1;
            if (m == 2 && k < 31) pins.serialIn = din[30 - k];
            repeat (4) @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask : read
endmodule : sarcv_host
`default_nettype wire

// ### verification/test_sar_adc_conversion_serial_readout.sv
// Self-checking bench for the conversion sequencer and readout
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_conversion_serial_readout
    import sarcv_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [RESULT_W-1:0] sampleData = '0;
    logic sampleValid = 1'b0;
    logic sampleReady, busy, chainMode;
    sarcv_pins_t pins;
    sarcv_out_t pinOut;
    int error_cnt = 0;
    int n_checks = 0;
    logic [RESULT_W-1:0] q[$];
    initial forever #20 clk = ~clk;
    sarcv_top dut (.clk(clk), .resetn(resetn), .pins(pins),
        .pinOut(pinOut), .sampleData(sampleData),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .busy(busy), .chainMode(chainMode));
    sarcv_host host (.clk(clk), .pinOut(pinOut), .pins(pins));
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic waitBusy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl) begin
            @(negedge clk);
            n++;
            if (n > 300) begin
                chk("busy", 32'(lvl), 32'(busy));
                results();
            end
        end
    endtask : waitBusy
    initial begin
        logic [31:0] din, got, exp;
        int n, m;
        n = $urandom(52);
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        sampleValid = 1'b1;
        for (int i = 0; i < 20; i++) begin
            sampleData = 16'($urandom);
            if (sampleReady === 1'b1) q.push_back(sampleData);
            @(negedge clk);
        end
        sampleValid = 1'b0;
        chk("fill", 32'(FIFO_DEPTH), 32'(q.size()));
        chk("full", 32'h0, 32'(sampleReady));
        $display("fill test done");
        // Modes rotate; the last start finds the store empty
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            m = i % 3;
            exp = q.size() > 0 ? 32'(q.pop_front()) : 32'h0;
            din = $urandom;
            host.start(m != 2);
            waitBusy(1'b1, n);
            waitBusy(1'b0, n);
            chk("busy cycles", 32'(CONV_CYC), 32'(n));
            chk("chain mode", 32'(m == 2), 32'(chainMode));
            host.read(m == 2 ? 32 : 16, m, din, got);
            if (m == 2) exp = {exp[15:0], din[31:16]};
            chk("result", exp, got);
            chk("release", 32'(m != 2), 32'(pinOut.serialOutEn_n));
            $display("conversion test %0d done", i);
        end
        results();
    end
endmodule : test_sar_adc_conversion_serial_readout
`default_nettype wire
